// *** logic/lsfs_device.sv ***
// line channel end: state decode, fault output, thermal shutdown, disconnect entry
// assumes the controller end on the same clk_sys; analog conditions arrive as comparator levels
`timescale 1ns/10ps
module lsfs_device
  import lsfs_pkg::*;
#(
  parameter int REV_CNT_W = 8
)
(
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   srst,
  // link to controller
  lsfs_link_if.device link,
  // analog comparator levels
  input  wire logic   long_fault_in,
  input  wire logic   tip_above_gnd,
  input  wire logic   ring_above_gnd,
  input  wire logic   tip_near_rail,
  input  wire logic   ring_near_rail,
  input  wire logic   temp_trip_hot,
  input  wire logic   temp_below_cool,
  input  wire logic   loop_current_in,
  // channel controls
  output lsfs_mode_t  mode_applied,
  output logic        voice_en,
  output logic        ilim_reduced,
  output logic        sense_reduced,
  output logic        amp_en,
  output logic        polarity_rev,
  output logic        ringing_en,
  output logic        low_bias,
  output logic        switcher_en,
  output logic        overheat_shutdown
);

  if (REVPASS_CYC < 1 || REVPASS_CYC >= (1 << REV_CNT_W))
    $error("lsfs_device: REV_CNT_W too small for reverse pass count");

  logic [7:0]           sync_q;
  logic                 long_s;
  logic                 tip_gnd_s;
  logic                 ring_gnd_s;
  logic                 tip_rail_s;
  logic                 ring_rail_s;
  logic                 hot_s;
  logic                 cool_s;
  logic                 loop_s;

  lsfs_mode_t           cmd_r;
  lsfs_mode_t           applied_r;
  lsfs_mode_t           applied_nxt;
  lsfs_phase_t          phase_r;
  lsfs_phase_t          phase_nxt;
  logic [REV_CNT_W-1:0] cnt_r;
  logic [REV_CNT_W-1:0] cnt_nxt;

  logic                 fault_n_r;
  logic                 sense_r;

  lsfs_sync #(.W(8)) u_sync
  (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d_async ({loop_current_in, temp_below_cool, temp_trip_hot, ring_near_rail,
               tip_near_rail, ring_above_gnd, tip_above_gnd, long_fault_in}),
    .q_sync  (sync_q)
  );

  assign long_s      = sync_q[0];
  assign tip_gnd_s   = sync_q[1];
  assign ring_gnd_s  = sync_q[2];
  assign tip_rail_s  = sync_q[3];
  assign ring_rail_s = sync_q[4];
  assign hot_s       = sync_q[5];
  assign cool_s      = sync_q[6];
  assign loop_s      = sync_q[7];

  // select decode
  wire lsfs_mode_t cmd_in  = lsfs_mode_t'({link.state_sel_bit2, link.state_sel_bit1,
                                           link.state_sel_bit0});
  wire             cmd_ok  = (cmd_in != MODE_RSVD6) && (cmd_in != MODE_RSVD7);
  wire             in_hot  = (phase_r == PH_HOT);
  wire             in_pass = (phase_r == PH_PASSREV);
  wire             recover = cool_s && !hot_s;

  // state sequencing
  always_comb
  begin
    applied_nxt = applied_r;
    phase_nxt   = phase_r;
    cnt_nxt     = cnt_r;
    unique case (phase_r)
      PH_RUN:
      begin
        if (hot_s)
          phase_nxt = PH_HOT;
        else if (cmd_r != applied_r)
        begin
          if (cmd_r == MODE_DISC)
          begin
            phase_nxt = PH_PASSREV;
            cnt_nxt   = REV_CNT_W'(REVPASS_CYC - 1);
          end
          else
            applied_nxt = cmd_r;
        end
      end
      PH_PASSREV:
      begin
        if (hot_s)
          phase_nxt = PH_HOT;
        else if (cnt_r == '0)
        begin
          applied_nxt = MODE_DISC;
          phase_nxt   = PH_RUN;
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      PH_HOT:
      begin
        if (recover)
        begin
          applied_nxt = cmd_r;
          phase_nxt   = PH_RUN;
        end
      end
      default:
      begin
        phase_nxt = PH_RUN;
      end
    endcase
  end

  // mode in force, reverse during the pass
  wire lsfs_mode_t eff = in_pass ? MODE_REVERSE : applied_r;

  wire is_stby = (eff == MODE_STANDBY);
  wire is_disc = (eff == MODE_DISC);
  wire is_act  = (eff == MODE_ACTIVE);
  wire is_rev  = (eff == MODE_REVERSE);
  wire is_ring = (eff == MODE_RINGING);
  wire is_test = (eff == MODE_LINETEST);
  wire on      = !in_hot && !is_disc;

  wire voice_nxt  = !in_hot && (is_act || is_rev);
  wire ilim_nxt   = !in_hot && is_stby;
  wire sense_nxt  = !in_hot && (is_stby || is_test);
  wire pol_nxt    = !in_hot && is_rev;
  wire ring_nxt   = !in_hot && (is_ring || is_test);
  wire bias_nxt   = !in_hot && is_test;
  wire sw_nxt     = on;

  // fault detection
  wire fv_norm = (is_act || is_stby) && (tip_gnd_s || ring_rail_s);
  wire fv_rev  = is_rev && (ring_gnd_s || tip_rail_s);
  wire det     = on && (long_s || fv_norm || fv_rev);
  wire fault_n_nxt = !det;

  wire loop_nxt = in_hot ? 1'b1 : (on && loop_s);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cmd_r     <= MODE_DISC;
      applied_r <= MODE_DISC;
      phase_r   <= PH_RUN;
      cnt_r     <= '0;
    end
    else
    begin
      if (cmd_ok)
        cmd_r <= cmd_in;
      applied_r <= applied_nxt;
      phase_r   <= phase_nxt;
      cnt_r     <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode_applied      <= MODE_DISC;
      voice_en          <= 1'b0;
      ilim_reduced      <= 1'b0;
      sense_reduced     <= 1'b0;
      amp_en            <= 1'b0;
      polarity_rev      <= 1'b0;
      ringing_en        <= 1'b0;
      low_bias          <= 1'b0;
      switcher_en       <= 1'b0;
      overheat_shutdown <= 1'b0;
      fault_n_r         <= 1'b1;
      sense_r           <= 1'b0;
    end
    else
    begin
      mode_applied      <= eff;
      voice_en          <= voice_nxt;
      ilim_reduced      <= ilim_nxt;
      sense_reduced     <= sense_nxt;
      amp_en            <= on;
      polarity_rev      <= pol_nxt;
      ringing_en        <= ring_nxt;
      low_bias          <= bias_nxt;
      switcher_en       <= sw_nxt;
      overheat_shutdown <= in_hot;
      fault_n_r         <= fault_n_nxt;
      sense_r           <= loop_nxt;
    end
  end

  assign link.fault_n        = fault_n_r;
  assign link.loop_sense_out = sense_r;

endmodule // lsfs_device

// *** logic/lsfs_pkg.sv ***
// shared constants, modes and register map of the line state and fault supervisor
// assumes a single 100 MHz system clock for both ends
package lsfs_pkg;

  typedef enum logic [2:0]
  {
    MODE_STANDBY  = 3'b000,
    MODE_DISC     = 3'b001,
    MODE_ACTIVE   = 3'b010,
    MODE_REVERSE  = 3'b011,
    MODE_RINGING  = 3'b100,
    MODE_LINETEST = 3'b101,
    MODE_RSVD6    = 3'b110,
    MODE_RSVD7    = 3'b111
  } lsfs_mode_t;

  typedef enum logic [1:0]
  {
    PH_RUN     = 2'b00,
    PH_PASSREV = 2'b01,
    PH_HOT     = 2'b10
  } lsfs_phase_t;

  localparam int CLK_FREQ_MHZ    = 100;
  localparam int REVPASS_TIME_NS = 2000;
  localparam int REVPASS_CYC     = (REVPASS_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int SETTLE_TIME_MS  = 3000;
  localparam int SETTLE_CYC_DFLT = SETTLE_TIME_MS * 1000 * CLK_FREQ_MHZ;

  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_INT_STAT = 4'h8;
  localparam logic [3:0] REG_INT_MASK = 4'hC;

  localparam int ST_FAULT_BIT = 3;
  localparam int ST_SENSE_BIT = 4;
  localparam int ST_READY_BIT = 5;

  localparam int INT_W           = 3;
  localparam int INT_FAULT_BIT   = 0;
  localparam int INT_SENSE_BIT   = 1;
  localparam int INT_SETTLED_BIT = 2;

endpackage

// *** logic/lsfs_link_if.sv ***
// link between controller and line channel: state select in, fault and loop sense out
// assumes both ends run on the same clk_sys
`timescale 1ns/10ps
interface lsfs_link_if;
  logic state_sel_bit0;
  logic state_sel_bit1;
  logic state_sel_bit2;
  logic fault_n;
  logic loop_sense_out;

  modport device
  (
    input  state_sel_bit0,
    input  state_sel_bit1,
    input  state_sel_bit2,
    output fault_n,
    output loop_sense_out
  );

  modport host
  (
    output state_sel_bit0,
    output state_sel_bit1,
    output state_sel_bit2,
    input  fault_n,
    input  loop_sense_out
  );
endinterface // lsfs_link_if

// *** logic/lsfs_sync.sv ***
// two flip-flop synchroniser for a group of asynchronous levels
// assumes inputs come from analog comparators outside the clock domain
`timescale 1ns/10ps
module lsfs_sync
#(
  parameter int W = 8
)
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         srst,
  // levels
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);
  logic [W-1:0] meta_r;

  if (W < 1) $error("lsfs_sync: W must be at least 1");

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta_r <= '0;
      q_sync <= '0;
    end
    else
    begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end
endmodule // lsfs_sync

// *** logic/lsfs_host.sv ***
// controller end: Avalon-MM registers, state select drive, settle timer, interrupt
// assumes the line channel end on the same clk_sys
`timescale 1ns/10ps
module lsfs_host
  import lsfs_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYC_DFLT,
  parameter int CNT_W      = $clog2(SETTLE_CYC + 2)
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq,
  // link to line channel
  lsfs_link_if.host        link
);

  if (SETTLE_CYC < 1 || CNT_W > 31 || SETTLE_CYC >= (1 << CNT_W))
    $error("lsfs_host: bad SETTLE_CYC or CNT_W");

  lsfs_mode_t       ctrl_r;
  logic [INT_W-1:0] mask_r;
  logic [INT_W-1:0] stat_r;
  logic [CNT_W-1:0] cnt_r;
  logic             ready_r;
  logic             fault_prev_r;
  logic             sense_prev_r;

  // bus decode
  wire req     = avs_read || avs_write;
  wire start   = req && avs_waitrequest;
  wire done    = req && !avs_waitrequest;
  wire hit_ctl = (avs_address == REG_CTRL);
  wire hit_st  = (avs_address == REG_STATUS);
  wire hit_is  = (avs_address == REG_INT_STAT);
  wire hit_im  = (avs_address == REG_INT_MASK);

  wire lsfs_mode_t wr_code = lsfs_mode_t'(avs_writedata[2:0]);
  wire wr_ok   = (wr_code != MODE_RSVD6) && (wr_code != MODE_RSVD7);
  wire wr_ctl  = done && avs_write && hit_ctl && wr_ok;
  wire wr_msk  = done && avs_write && hit_im;
  wire rd_clr  = done && avs_read && hit_is;

  wire [31:0] st_word = {26'h0, ready_r, link.loop_sense_out, !link.fault_n, ctrl_r};
  wire [31:0] rd_mux  = hit_ctl ? {29'h0, ctrl_r} :
                        hit_st  ? st_word :
                        hit_is  ? {29'h0, stat_r} :
                        hit_im  ? {29'h0, mask_r} : 32'h0;

  // settle timer after disconnect
  wire new_disc  = wr_ctl && (wr_code == MODE_DISC) && (ctrl_r != MODE_DISC);
  wire hold      = (ctrl_r != MODE_DISC) || new_disc;
  wire reach     = (cnt_r == CNT_W'(SETTLE_CYC));
  wire ready_nxt = !hold && (ready_r || reach);

  // events
  logic [INT_W-1:0] ev;
  assign ev[INT_FAULT_BIT]   = fault_prev_r && !link.fault_n;
  assign ev[INT_SENSE_BIT]   = !sense_prev_r && link.loop_sense_out;
  assign ev[INT_SETTLED_BIT] = ready_nxt && !ready_r;

  wire [INT_W-1:0] clr      = rd_clr ? avs_readdata[INT_W-1:0] : '0;
  wire [INT_W-1:0] stat_nxt = (stat_r & ~clr) | ev;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      ctrl_r          <= MODE_DISC;
      mask_r          <= '0;
      stat_r          <= '0;
      irq             <= 1'b0;
      cnt_r           <= '0;
      ready_r         <= 1'b0;
      fault_prev_r    <= 1'b1;
      sense_prev_r    <= 1'b0;
    end
    else
    begin
      avs_waitrequest <= !start;
      if (start && avs_read)
        avs_readdata <= rd_mux;
      if (wr_ctl)
        ctrl_r <= wr_code;
      if (wr_msk)
        mask_r <= avs_writedata[INT_W-1:0];
      stat_r       <= stat_nxt;
      irq          <= |(stat_nxt & mask_r);
      cnt_r        <= (hold || ready_r) ? '0 : cnt_r + 1'b1;
      ready_r      <= ready_nxt;
      fault_prev_r <= link.fault_n;
      sense_prev_r <= link.loop_sense_out;
    end
  end

  assign link.state_sel_bit0 = ctrl_r[0];
  assign link.state_sel_bit1 = ctrl_r[1];
  assign link.state_sel_bit2 = ctrl_r[2];

endmodule // lsfs_host

// *** verif/lsfs_asserts.sv ***
// checker on the controller to line channel link and channel controls
// assumes one clk_sys domain; tb instantiates it beside the link
`timescale 1ns/10ps
module lsfs_asserts
  import lsfs_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       srst,
  // link
  input wire logic       state_sel_bit0,
  input wire logic       state_sel_bit1,
  input wire logic       state_sel_bit2,
  input wire logic       fault_n,
  input wire logic       loop_sense_out,
  // comparators
  input wire logic       long_fault_in,
  input wire logic       temp_trip_hot,
  input wire logic       temp_below_cool,
  // channel controls
  input wire lsfs_mode_t mode_applied,
  input wire logic       voice_en,
  input wire logic       polarity_rev,
  input wire logic       switcher_en,
  input wire logic       overheat_shutdown
);
  wire logic [2:0] sel = {state_sel_bit2, state_sel_bit1, state_sel_bit0};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  AST_ACTIVE_APPLY: assert property ((sel == MODE_ACTIVE && !overheat_shutdown) [*5]
    |-> mode_applied == MODE_ACTIVE && voice_en && !polarity_rev) else $error("active lost");
  AST_REV_POL: assert property (mode_applied == MODE_REVERSE && !overheat_shutdown
    |-> polarity_rev) else $error("reverse without polarity");
  AST_DISC_VIA_REV: assert property (mode_applied == MODE_DISC
    && $past(mode_applied) != MODE_DISC && !$past(overheat_shutdown)
    |-> $past(mode_applied) == MODE_REVERSE) else $error("no reverse pass");
  AST_DISC_QUIET: assert property ((mode_applied == MODE_DISC) [*3]
    |-> fault_n && !switcher_en) else $error("disconnect not quiet");
  AST_LONG_FAULT: assert property ((long_fault_in && mode_applied != MODE_DISC
    && !overheat_shutdown) [*4] |-> !fault_n) else $error("long fault missed");
  AST_HOT_OFF: assert property (temp_trip_hot [*5] |-> overheat_shutdown
    && loop_sense_out && !switcher_en && fault_n) else $error("overheat not handled");
  AST_COOL_BACK: assert property ((temp_below_cool && !temp_trip_hot) [*5]
    |-> !overheat_shutdown) else $error("no recovery");
  AST_HOLD_HOT: assert property ((!temp_below_cool) [*4] ##0 overheat_shutdown
    |=> overheat_shutdown) else $error("left overheat early");
endmodule // lsfs_asserts

// *** verif/tb.sv ***
// bench: controller and channel on one link, a second channel fed reserved codes
// assumes package, interface and design files compiled first
`timescale 1ns/10ps
module tb;
  import lsfs_pkg::*;
  logic        clk_sys;
  logic        srst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [7:0]  ana;
  logic [2:0]  sel2;
  wire  [8:0]  ctl;
  logic [31:0] rd;
  lsfs_mode_t  mode_applied;
  lsfs_mode_t  mode2;
  int          failures = 0;
  int          n_compared = 0;
  lsfs_mode_t  codes [5] = '{MODE_ACTIVE, MODE_STANDBY, MODE_REVERSE, MODE_RINGING,
                             MODE_LINETEST};
  logic [15:0] ft [9] = '{16'h2021, 16'h2101, 16'h2040, 16'h3041, 16'h3081, 16'h3020,
                          16'h0021, 16'h4011, 16'h4020};

  lsfs_link_if link ();
  lsfs_link_if link2 ();
  assign {link2.state_sel_bit2, link2.state_sel_bit1, link2.state_sel_bit0} = sel2;

  lsfs_host #(.SETTLE_CYC(20)) lsfs_host_inst (.clk_sys(clk_sys), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .link(link));
  lsfs_device lsfs_device_inst (.clk_sys(clk_sys), .srst(srst), .link(link),
    .long_fault_in(ana[0]), .tip_above_gnd(ana[1]), .ring_above_gnd(ana[2]),
    .tip_near_rail(ana[3]), .ring_near_rail(ana[4]), .temp_trip_hot(ana[5]),
    .temp_below_cool(ana[6]), .loop_current_in(ana[7]), .mode_applied(mode_applied),
    .voice_en(ctl[0]), .ilim_reduced(ctl[1]), .sense_reduced(ctl[2]), .amp_en(ctl[3]),
    .polarity_rev(ctl[4]), .ringing_en(ctl[5]), .low_bias(ctl[6]),
    .switcher_en(ctl[7]), .overheat_shutdown(ctl[8]));
  lsfs_device lsfs_device_inst_2 (.clk_sys(clk_sys), .srst(srst), .link(link2),
    .long_fault_in(ana[0]), .tip_above_gnd(ana[1]), .ring_above_gnd(ana[2]),
    .tip_near_rail(ana[3]), .ring_near_rail(ana[4]), .temp_trip_hot(ana[5]),
    .temp_below_cool(ana[6]), .loop_current_in(ana[7]), .mode_applied(mode2),
    .voice_en(), .ilim_reduced(), .sense_reduced(), .amp_en(), .polarity_rev(),
    .ringing_en(), .low_bias(), .switcher_en(), .overheat_shutdown());
  lsfs_asserts lsfs_asserts_inst (.clk_sys(clk_sys), .srst(srst),
    .state_sel_bit0(link.state_sel_bit0), .state_sel_bit1(link.state_sel_bit1),
    .state_sel_bit2(link.state_sel_bit2), .fault_n(link.fault_n),
    .loop_sense_out(link.loop_sense_out), .long_fault_in(ana[0]),
    .temp_trip_hot(ana[5]), .temp_below_cool(ana[6]), .mode_applied(mode_applied),
    .voice_en(ctl[0]), .polarity_rev(ctl[4]), .switcher_en(ctl[7]),
    .overheat_shutdown(ctl[8]));

  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  // one bus cycle, entered just after an edge, left just after an edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task conclude;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    conclude();
  end

  initial
  begin
    srst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    ana = 8'h40;
    sel2 = MODE_ACTIVE;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rdc(REG_CTRL, 32'h1);
    av(1'b1, REG_CTRL, 32'h6);
    rdc(REG_CTRL, 32'h1);
    w(30);
    rdc(REG_STATUS, 32'h21);
    rdc(REG_INT_STAT, 32'h4);
    for (int c = 6; c < 8; c++)
    begin
      chk(mode2, MODE_ACTIVE);
      sel2 <= c[2:0];
      w(5);
    end
    chk(mode2, MODE_ACTIVE);
    foreach (codes[i])
    begin
      av(1'b1, REG_CTRL, {29'h0, codes[i]});
      w(6);
      chk(mode_applied, codes[i]);
      chk(ctl, {1'b0, 1'b1, codes[i] == MODE_LINETEST,
        (codes[i] inside {MODE_RINGING, MODE_LINETEST}), codes[i] == MODE_REVERSE, 1'b1,
        (codes[i] inside {MODE_STANDBY, MODE_LINETEST}), codes[i] == MODE_STANDBY,
        (codes[i] inside {MODE_ACTIVE, MODE_REVERSE})});
      rdc(REG_STATUS, {29'h0, codes[i]});
    end
    foreach (ft[i])
    begin
      av(1'b1, REG_CTRL, {28'h0, ft[i][15:12]});
      ana <= 8'h40 | ft[i][11:4];
      w(6);
      chk(link.fault_n, !ft[i][0]);
      rdc(REG_STATUS, {28'h0, ft[i][0], ft[i][14:12]});
      ana <= 8'h40;
      w(5);
      chk(link.fault_n, 1'b1);
    end
    chk(irq, 1'b0);
    rdc(REG_INT_STAT, 32'h1);
    av(1'b1, REG_INT_MASK, 32'h7);
    rdc(REG_INT_MASK, 32'h7);
    ana <= 8'h41;
    w(5);
    chk(irq, 1'b1);
    rdc(REG_INT_STAT, 32'h1);
    w(2);
    chk(irq, 1'b0);
    ana <= 8'hC0;
    w(5);
    rdc(REG_STATUS, 32'h14);
    rdc(REG_INT_STAT, 32'h2);
    ana <= 8'h40;
    av(1'b1, REG_CTRL, {29'h0, MODE_ACTIVE});
    w(6);
    ana <= 8'h20;
    w(5);
    chk({ctl[8], ctl[7], link.loop_sense_out, link.fault_n}, 4'hB);
    av(1'b1, REG_CTRL, {29'h0, MODE_REVERSE});
    ana <= 8'h00;
    w(8);
    chk(ctl[8], 1'b1);
    ana <= 8'h40;
    w(6);
    chk({ctl[8], mode_applied}, {1'b0, MODE_REVERSE});
    rdc(REG_INT_STAT, 32'h2);
    av(1'b1, REG_CTRL, {29'h0, MODE_ACTIVE});
    w(6);
    av(1'b1, REG_CTRL, {29'h0, MODE_DISC});
    rdc(REG_STATUS, 32'h1);
    w(10);
    chk({mode_applied, ctl[4]}, {MODE_REVERSE, 1'b1});
    w(30);
    rdc(REG_STATUS, 32'h21);
    rdc(REG_INT_STAT, 32'h4);
    w(200);
    chk({mode_applied, ctl[7], ctl[3]}, {MODE_DISC, 2'b00});
    ana <= 8'h41;
    w(5);
    chk(link.fault_n, 1'b1);
    conclude();
  end
endmodule // tb
